// [logic/tcp_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tcp_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic cpu_irq_mask,
  output logic timer_irq,
  input wire logic ext_clk,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  output logic compare_output_pin_one,
  output logic compare_output_pin_one_oe,
  output logic compare_output_pin_two,
  output logic compare_output_pin_two_oe
);
  import tcp_pkg::*;

  // Register state.
  logic [7:0] first_control_reg_q;
  logic [7:0] second_control_reg_q;
  logic [15:0] cmp_q [2];
  logic [15:0] shadow_q [2];
  logic [1:0] inhibit_q;
  logic [15:0] count_q;
  logic [15:0] cap1_q;
  logic [15:0] cap2_q;
  logic [4:0] flags_q;
  logic [4:0] armed_q;
  logic [1:0] eq_q;
  logic pin1_q;
  logic pin2_q;
  logic irq_q;
  logic wrap_q;
  logic [7:0] rdata_q;

  // Decoded modes and accesses.
  logic pwm_mode;
  logic opm_mode;
  logic level_one;
  logic level_two;
  logic plus_one;
  logic [1:0] cap_edge;
  logic [1:0] hit;
  logic [1:0] eq;
  logic [15:0] target [2];
  logic [4:0] flag_set;
  logic [4:0] flag_acc;
  logic sr_read;
  logic opm_trig;
  logic cap1_take;
  logic period_end;
  logic count_write;
  logic force_one;
  logic force_two;
  logic [1:0] low_wr;
  logic [1:0] high_wr;

  tcp_tick_if tk ();

  tcp_prescale u_prescale (
    .clock(clock),
    .rst_n(rst_n),
    .ext_clk(ext_clk),
    .tk(tk.src)
  );

  tcp_edge_sync #(.W(2)) u_capture_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin({capture_input_two, capture_input_one}),
    .rising_sel({second_control_reg_q[C2_EDGE_TWO],
                 first_control_reg_q[C1_EDGE_ONE]}),
    .edge_pulse(cap_edge)
  );

  assign tk.clock_select =
    second_control_reg_q[C2_CLK_SEL_HI:C2_CLK_SEL_LO];
  assign tk.ext_edge_sel = second_control_reg_q[C2_EXT_EDGE];

  // Mode decode; modulation wins when both select bits are set.
  assign pwm_mode = second_control_reg_q[C2_PWM];
  assign opm_mode = second_control_reg_q[C2_ONE_PULSE] & ~pwm_mode;
  assign level_one = first_control_reg_q[C1_LEVEL_ONE];
  assign level_two = first_control_reg_q[C1_LEVEL_TWO];
  assign plus_one = (tk.clock_select != CLK_DIV2);

  // Bus decode.
  assign sr_read = rd && (addr == ADDR_STATUS);
  assign high_wr[0] = wr && (addr == ADDR_CMP1_HIGH);
  assign high_wr[1] = wr && (addr == ADDR_CMP2_HIGH);
  assign low_wr[0] = wr && (addr == ADDR_CMP1_LOW);
  assign low_wr[1] = wr && (addr == ADDR_CMP2_LOW);
  assign count_write = wr && (addr == ADDR_COUNT_LOW);
  assign force_one = wr && (addr == ADDR_FIRST_CONTROL) &&
                     wdata[C1_FORCE_ONE] && !opm_mode && !pwm_mode;
  assign force_two = wr && (addr == ADDR_FIRST_CONTROL) &&
                     wdata[C1_FORCE_TWO] && !opm_mode && !pwm_mode;

  // Compare detection per channel, one pulse on the first equal cycle.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_cmp
      logic [15:0] ref_val;
      assign ref_val = pwm_mode ? shadow_q[i] : cmp_q[i];
      assign target[i] = plus_one ? ref_val + 16'h0001 : ref_val;
      assign eq[i] = (count_q == target[i]);
      assign hit[i] = eq[i] && !eq_q[i] &&
                      (pwm_mode || !inhibit_q[i]);
    end
  endgenerate

  // Events that reload the counter or capture.
  assign opm_trig = opm_mode && cap_edge[0];
  assign cap1_take = cap_edge[0] && !pwm_mode;
  assign period_end = pwm_mode && hit[1];

  // Flag set terms; compare flags never set in modulation mode.
  always_comb begin
    flag_set = 5'b00000;
    flag_set[FLG_CMP1] = hit[0] && !pwm_mode && !opm_mode;
    flag_set[FLG_CMP2] = hit[1] && !pwm_mode;
    flag_set[FLG_CAP1] = cap1_take || period_end;
    flag_set[FLG_CAP2] = cap_edge[1];
    flag_set[FLG_OVF] = tk.tick && (count_q == COUNT_MAX) && !wrap_q &&
                        !opm_trig && !period_end && !count_write;
  end

  // Second clearing step: access to the matching low byte.
  always_comb begin
    flag_acc = 5'b00000;
    flag_acc[FLG_CMP1] = (rd || wr) && (addr == ADDR_CMP1_LOW);
    flag_acc[FLG_CMP2] = (rd || wr) && (addr == ADDR_CMP2_LOW);
    flag_acc[FLG_CAP1] = (rd || wr) && (addr == ADDR_CAP1_LOW);
    flag_acc[FLG_CAP2] = (rd || wr) && (addr == ADDR_CAP2_LOW);
    flag_acc[FLG_OVF] = (rd || wr) && (addr == ADDR_COUNT_LOW);
  end

  // Control registers; force bits are actions and are not stored.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_control_reg_q <= CTRL_RESET;
      second_control_reg_q <= CTRL_RESET;
    end else if (wr) begin
      if (addr == ADDR_FIRST_CONTROL) begin
        first_control_reg_q <= wdata &
          ~((8'h01 << C1_FORCE_ONE) | (8'h01 << C1_FORCE_TWO));
      end
      if (addr == ADDR_SECOND_CONTROL) begin
        second_control_reg_q <= wdata;
      end
    end
  end

  // Compare values, write lock and modulation shadows.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q[0] <= CMP_RESET;
      cmp_q[1] <= CMP_RESET;
      shadow_q[0] <= CMP_RESET;
      shadow_q[1] <= CMP_RESET;
      inhibit_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (high_wr[i]) begin
          cmp_q[i][15:8] <= wdata;
          inhibit_q[i] <= 1'b1;
        end else if (low_wr[i]) begin
          cmp_q[i][7:0] <= wdata;
          inhibit_q[i] <= 1'b0;
        end
        if (!pwm_mode) begin
          shadow_q[i] <= cmp_q[i];
        end else if (period_end && !inhibit_q[i]) begin
          shadow_q[i] <= cmp_q[i];
        end
      end
    end
  end

  // Equality history so a match acts once.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eq_q <= 2'b00;
    end else begin
      eq_q <= eq;
    end
  end

  // At half rate the period value stands one full count before the reload.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrap_q <= 1'b0;
    end else if (period_end && !plus_one) begin
      wrap_q <= 1'b1;
    end else if (tk.tick || !pwm_mode) begin
      wrap_q <= 1'b0;
    end
  end

  // Free-running counter with its reload events.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= COUNT_RELOAD;
    end else if (opm_trig || count_write || (period_end && plus_one)) begin
      count_q <= COUNT_RELOAD;
    end else if (tk.tick) begin
      count_q <= wrap_q ? COUNT_RELOAD : count_q + 16'h0001;
    end
  end

  // Capture registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
    end else begin
      if (cap1_take) begin
        cap1_q <= count_q;
      end
      if (cap_edge[1]) begin
        cap2_q <= count_q;
      end
    end
  end

  // Sticky flags: a set in the clearing cycle wins.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= 5'b00000;
      armed_q <= 5'b00000;
    end else begin
      for (int i = 0; i < 5; i++) begin
        flags_q[i] <= flag_set[i] ||
                      (flags_q[i] && !(armed_q[i] && flag_acc[i]));
        if (sr_read) begin
          armed_q[i] <= flags_q[i];
        end else if (flag_acc[i]) begin
          armed_q[i] <= 1'b0;
        end
      end
    end
  end

  // Compare pin one latch in the three modes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin1_q <= 1'b0;
    end else if (second_control_reg_q[C2_PIN_EN_ONE]) begin
      if (pwm_mode) begin
        if (hit[1]) begin
          pin1_q <= level_two;
        end else if (hit[0]) begin
          pin1_q <= level_one;
        end
      end else if (opm_mode) begin
        if (opm_trig) begin
          pin1_q <= level_two;
        end else if (hit[0]) begin
          pin1_q <= level_one;
        end
      end else if (hit[0] || force_one) begin
        pin1_q <= level_one;
      end
    end
  end

  // Compare pin two latch; idle in one-pulse and modulation modes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin2_q <= 1'b0;
    end else if (second_control_reg_q[C2_PIN_EN_TWO] && !opm_mode &&
                 !pwm_mode && (hit[1] || force_two)) begin
      pin2_q <= level_two;
    end
  end

  // Output enables follow the pin enable bits.
  assign compare_output_pin_one = pin1_q;
  assign compare_output_pin_two = pin2_q;
  assign compare_output_pin_one_oe = second_control_reg_q[C2_PIN_EN_ONE];
  assign compare_output_pin_two_oe = second_control_reg_q[C2_PIN_EN_TWO];

  // Timer interrupt request, gated by enables and the processor mask.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= !cpu_irq_mask &&
        ((first_control_reg_q[C1_CMP_IRQ_EN] &&
          (flags_q[FLG_CMP1] || flags_q[FLG_CMP2])) ||
         (first_control_reg_q[C1_CAP_IRQ_EN] &&
          (flags_q[FLG_CAP1] || flags_q[FLG_CAP2])) ||
         (first_control_reg_q[C1_OVF_IRQ_EN] && flags_q[FLG_OVF]));
    end
  end
  assign timer_irq = irq_q;

  // Read data appear in the cycle after the read strobe, zero otherwise.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        ADDR_FIRST_CONTROL: rdata_q <= first_control_reg_q;
        ADDR_SECOND_CONTROL: rdata_q <= second_control_reg_q;
        ADDR_STATUS: rdata_q <= {flags_q, 3'b000};
        ADDR_CMP1_HIGH: rdata_q <= cmp_q[0][15:8];
        ADDR_CMP1_LOW: rdata_q <= cmp_q[0][7:0];
        ADDR_CMP2_HIGH: rdata_q <= cmp_q[1][15:8];
        ADDR_CMP2_LOW: rdata_q <= cmp_q[1][7:0];
        ADDR_COUNT_HIGH: rdata_q <= count_q[15:8];
        ADDR_COUNT_LOW: rdata_q <= count_q[7:0];
        ADDR_CAP1_HIGH: rdata_q <= cap1_q[15:8];
        ADDR_CAP1_LOW: rdata_q <= cap1_q[7:0];
        ADDR_CAP2_HIGH: rdata_q <= cap2_q[15:8];
        ADDR_CAP2_LOW: rdata_q <= cap2_q[7:0];
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata = rdata_q;
endmodule : tcp_top
`default_nettype wire

// [logic/tcp_pkg.sv]
package tcp_pkg;
  // Register offsets on the 4-bit address port.
  localparam logic [3:0] ADDR_FIRST_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SECOND_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CMP1_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CMP1_LOW = 4'h4;
  localparam logic [3:0] ADDR_CMP2_HIGH = 4'h5;
  localparam logic [3:0] ADDR_CMP2_LOW = 4'h6;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h7;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h8;
  localparam logic [3:0] ADDR_CAP1_HIGH = 4'h9;
  localparam logic [3:0] ADDR_CAP1_LOW = 4'hA;
  localparam logic [3:0] ADDR_CAP2_HIGH = 4'hB;
  localparam logic [3:0] ADDR_CAP2_LOW = 4'hC;
  // First control register fields.
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_OVF_IRQ_EN = 5;
  localparam int C1_FORCE_TWO = 4;
  localparam int C1_LEVEL_TWO = 2;
  localparam int C1_EDGE_ONE = 1;
  localparam int C1_FORCE_ONE = 3;
  localparam int C1_LEVEL_ONE = 0;
  // Second control register fields.
  localparam int C2_PIN_EN_ONE = 7;
  localparam int C2_PIN_EN_TWO = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_SEL_HI = 3;
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_EDGE_TWO = 1;
  localparam int C2_EXT_EDGE = 0;
  // Flag vector indices; status bit is index plus FLAG_SHIFT.
  localparam int FLG_CAP1 = 4;
  localparam int FLG_CMP1 = 3;
  localparam int FLG_OVF = 2;
  localparam int FLG_CAP2 = 1;
  localparam int FLG_CMP2 = 0;
  localparam int FLAG_SHIFT = 3;
  // Reset and reload values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // Timer clock selection codes.
  localparam logic [1:0] CLK_DIV2 = 2'b00;
  localparam logic [1:0] CLK_DIV4 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_EXT = 2'b11;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;
endpackage : tcp_pkg

// [logic/tcp_tick_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Carries the clock selection to the prescaler and its tick back.
interface tcp_tick_if;
  logic [1:0] clock_select;
  logic ext_edge_sel;
  logic tick;
  modport src (input clock_select, input ext_edge_sel, output tick);
  modport dst (output clock_select, output ext_edge_sel, input tick);
endinterface : tcp_tick_if
`default_nettype wire

// [logic/tcp_edge_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module tcp_edge_sync #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  input wire logic [W-1:0] rising_sel,
  output logic [W-1:0] edge_pulse
);
  // Each pin passes three flip-flops; the edge is seen between the second and third.
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Rising or falling transition, as selected.
      assign edge_pulse[i] = rising_sel[i] ? (s2_q & ~s3_q) : (~s2_q & s3_q);
    end
  endgenerate
endmodule : tcp_edge_sync
`default_nettype wire

// [logic/tcp_prescale.sv]
`timescale 1ns/100ps
`default_nettype none
module tcp_prescale
  import tcp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ext_clk,
  tcp_tick_if.src tk
);
  logic [2:0] div_q;
  logic e1_q;
  logic e2_q;
  logic e3_q;
  logic tick_q;
  logic [2:0] mask;
  logic ext_edge;

  // Free divider of the system clock.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // External clock is synchronised before its edge is looked at.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      e1_q <= 1'b0;
      e2_q <= 1'b0;
      e3_q <= 1'b0;
    end else begin
      e1_q <= ext_clk;
      e2_q <= e1_q;
      e3_q <= e2_q;
    end
  end

  // Divider mask and external edge for the selected source.
  always_comb begin
    unique case (tk.clock_select)
      CLK_DIV2: mask = DIV2_MASK;
      CLK_DIV4: mask = DIV4_MASK;
      default: mask = DIV8_MASK;
    endcase
    ext_edge = tk.ext_edge_sel ? (e2_q & ~e3_q) : (~e2_q & e3_q);
  end

  // One-cycle tick per timer count.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else if (tk.clock_select == CLK_EXT) begin
      tick_q <= ext_edge;
    end else begin
      tick_q <= ((div_q & mask) == mask);
    end
  end

  assign tk.tick = tick_q;
endmodule : tcp_prescale
`default_nettype wire

// [tb/tcp_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module tcp_chk
  import tcp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic cpu_irq_mask,
  input wire logic timer_irq,
  input wire logic compare_output_pin_one,
  input wire logic compare_output_pin_one_oe,
  input wire logic compare_output_pin_two,
  input wire logic compare_output_pin_two_oe
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Pins, the first pin enable and the request are quiet right after reset.
  reset_outputs_low_a: assert property (
    $rose(rst_n) |-> !compare_output_pin_one && !compare_output_pin_two
      && !compare_output_pin_one_oe && !timer_irq)
    else $error("outputs not low after reset");

  // Read data is zero outside the cycle after a read.
  rdata_idle_zero_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero when idle");

  // Unmapped offsets read as zero.
  unmapped_read_zero_a: assert property (
    $past(rd) && ($past(addr) > ADDR_CAP2_LOW) |-> rdata == 8'h00)
    else $error("unmapped read not zero");

  // The second control register reads back what was written.
  ctrl_readback_a: assert property (
    wr && addr == ADDR_SECOND_CONTROL ##1 !wr ##1
      rd && addr == ADDR_SECOND_CONTROL |=> rdata == $past(wdata, 3))
    else $error("second control readback wrong");

  // Pin enables follow their control bits.
  pin_enable_follow_a: assert property (
    wr && addr == ADDR_SECOND_CONTROL |=>
      {compare_output_pin_one_oe, compare_output_pin_two_oe}
        == $past(wdata[7:6]))
    else $error("pin enable does not follow control");

  // A masked processor never sees the request.
  masked_irq_low_a: assert property ($past(cpu_irq_mask) |-> !timer_irq)
    else $error("request raised while masked");

  // A request only rises while the mask was clear.
  irq_rise_unmasked_a: assert property (
    $rose(timer_irq) |-> !$past(cpu_irq_mask))
    else $error("request rose under mask");

  // A disabled pin keeps its latch.
  pin_one_hold_a: assert property (
    !$past(compare_output_pin_one_oe) |-> $stable(compare_output_pin_one))
    else $error("disabled pin one changed");

  pin_two_hold_a: assert property (
    !$past(compare_output_pin_two_oe) |-> $stable(compare_output_pin_two))
    else $error("disabled pin two changed");
endmodule : tcp_chk

bind tcp_top tcp_chk u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .cpu_irq_mask(cpu_irq_mask),
  .timer_irq(timer_irq),
  .compare_output_pin_one(compare_output_pin_one),
  .compare_output_pin_one_oe(compare_output_pin_one_oe),
  .compare_output_pin_two(compare_output_pin_two),
  .compare_output_pin_two_oe(compare_output_pin_two_oe)
);
`default_nettype wire

// [tb/test_tcp_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_tcp_top;
  import tcp_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic cpu_irq_mask = 1'b0, ext_clk = 1'b0, cap_one = 1'b0, cap_two = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, v;
  logic timer_irq, pin_one, pin_one_oe, pin_two, pin_two_oe;
  int n_fail = 0, checks_done = 0, n, h, l;

  // Free running system clock.
  always #50 clock = ~clock;

  tcp_top dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask),
    .timer_irq(timer_irq), .ext_clk(ext_clk), .capture_input_one(cap_one),
    .capture_input_two(cap_two), .compare_output_pin_one(pin_one),
    .compare_output_pin_one_oe(pin_one_oe), .compare_output_pin_two(pin_two),
    .compare_output_pin_two_oe(pin_two_oe));

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Bus cycles: one strobe cycle, read data taken in the cycle after.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] m,
                        input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK(nm, e, d & m)
  endtask : chk_rd
  // Compare values go high byte first so the lock is released at the end.
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    logic [7:0] s;
    wr_reg(a, d[15:8]);
    rd_reg(ADDR_STATUS, s);
    wr_reg(a + 4'h1, d[7:0]);
  endtask : wr16

  // Bounded waits on the first pin and on a status flag.
  task automatic wait_pin(input logic lvl, input int lim, output int c);
    c = 0;
    while (pin_one !== lvl) begin
      @(posedge clock);
      #1;
      c++;
      if (c > lim) begin
        n_fail++;
        $display("mismatch pin_one expected %h seen timeout", lvl);
        finish_test();
      end
    end
  endtask : wait_pin
  task automatic wait_flag(input logic [7:0] m);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; (d & m) == 8'h00; i++) begin
      if (i > 100) begin
        n_fail++;
        $display("mismatch status expected %h seen timeout", m);
        finish_test();
      end
      rd_reg(ADDR_STATUS, d);
    end
  endtask : wait_flag

  // Main sequence.
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    `CHK("reset outputs", 3'b000, {pin_one, pin_two, timer_irq})
    chk_rd(ADDR_FIRST_CONTROL, 8'hFF, CTRL_RESET, "ctrl1");
    chk_rd(ADDR_CMP1_HIGH, 8'hFF, CMP_RESET[15:8], "cmp1 high");
    chk_rd(4'hF, 8'hFF, 8'h00, "unmapped");
    // Plain compare on channel one with its pin and request enabled.
    wr_reg(ADDR_SECOND_CONTROL, 8'h80);
    chk_rd(ADDR_SECOND_CONTROL, 8'hFF, 8'h80, "ctrl2");
    wr_reg(ADDR_FIRST_CONTROL, 8'h41);
    wr16(ADDR_CMP1_HIGH, 16'h0020);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wait_pin(1'b1, 200, n);
    chk_rd(ADDR_STATUS, 8'h40, 8'h40, "cmp1 flag");
    `CHK("irq", 1'b1, timer_irq)
    rd_reg(ADDR_CMP1_LOW, v);
    chk_rd(ADDR_STATUS, 8'h40, 8'h00, "cmp1 cleared");
    `CHK("irq cleared", 1'b0, timer_irq)
    // The processor mask holds the request back.
    @(posedge clock);
    cpu_irq_mask <= 1'b1;
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wait_flag(8'h40);
    `CHK("irq masked", 1'b0, timer_irq)
    @(posedge clock);
    cpu_irq_mask <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("irq unmasked", 1'b1, timer_irq)
    rd_reg(ADDR_CMP1_LOW, v);
    // A lone high byte write locks the compare; pin disabled ignores it.
    wr_reg(ADDR_SECOND_CONTROL, 8'h00);
    wr_reg(ADDR_FIRST_CONTROL, 8'h40);
    wr_reg(ADDR_CMP1_HIGH, 8'h00);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    repeat (150) @(posedge clock);
    chk_rd(ADDR_STATUS, 8'h40, 8'h00, "locked");
    wr_reg(ADDR_CMP1_LOW, 8'h20);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wait_flag(8'h40);
    `CHK("pin gpio", 1'b1, pin_one)
    repeat (2) @(posedge clock);
    #1;
    `CHK("irq gpio", 1'b1, timer_irq)
    rd_reg(ADDR_CMP1_LOW, v);
    // Forcing copies the level with no flag and no request.
    wr_reg(ADDR_SECOND_CONTROL, 8'h80);
    wr_reg(ADDR_FIRST_CONTROL, 8'h48);
    repeat (2) @(posedge clock);
    #1;
    `CHK("forced pin", 1'b0, pin_one)
    chk_rd(ADDR_STATUS, 8'h40, 8'h00, "force flag");
    `CHK("force irq", 1'b0, timer_irq)
    // Forcing is ignored in one-pulse mode.
    wr_reg(ADDR_SECOND_CONTROL, 8'hA0);
    wr_reg(ADDR_FIRST_CONTROL, 8'h09);
    repeat (2) @(posedge clock);
    #1;
    `CHK("force one pulse", 1'b0, pin_one)
    // One pulse triggered by a rising edge on capture one.
    wr_reg(ADDR_FIRST_CONTROL, 8'h46);
    wr16(ADDR_CMP1_HIGH, 16'h0040);
    @(posedge clock);
    cap_one <= 1'b1;
    wait_pin(1'b1, 20, n);
    chk_rd(ADDR_STATUS, 8'hC0, 8'h80, "trigger flags");
    rd_reg(ADDR_CAP1_LOW, v);
    wait_pin(1'b0, 300, n);
    `CHK("pulse length", 1'b1, (n > 120) && (n < 140))
    cap_one <= 1'b0;
    chk_rd(ADDR_STATUS, 8'hC0, 8'h00, "pulse end flags");
    `CHK("pulse irq", 1'b0, timer_irq)
    // Modulation with both mode bits set: only modulation runs.
    wr_reg(ADDR_SECOND_CONTROL, 8'hB0);
    wr_reg(ADDR_FIRST_CONTROL, 8'h01);
    wr16(ADDR_CMP1_HIGH, 16'h0010);
    wr16(ADDR_CMP2_HIGH, 16'h0030);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wait_pin(1'b1, 300, n);
    wait_pin(1'b0, 70000, n);
    wait_pin(1'b1, 200, n);
    wait_pin(1'b0, 200, h);
    wait_pin(1'b1, 200, l);
    `CHK("pulse high", 64, h)
    `CHK("period", 106, h + l)
    chk_rd(ADDR_STATUS, 8'hC8, 8'h80, "pwm flags");
    // A new duty value waits for the period end.
    wr16(ADDR_CMP1_HIGH, 16'h0020);
    wait_pin(1'b0, 200, n);
    wait_pin(1'b1, 200, n);
    wait_pin(1'b0, 200, h);
    `CHK("new pulse high", 32, h)
    finish_test();
  end
endmodule : test_tcp_top
`default_nettype wire
